// [inc/timer_ctl_pkg.sv]
// Shared constants and carriers of the timer control block
package timer_ctl_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_RELOAD = 12'h004;
  localparam logic [11:0] OFF_COUNT = 12'h008;
  localparam logic [15:0] CONTROL_RESET = 16'h0200;
  localparam logic [15:0] CONTROL_WRITABLE = 16'h07ff;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [15:0] WRAP_LOW = 16'h0000;
  localparam logic [15:0] WRAP_HIGH = 16'hffff;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int unsigned FILTER_DEPTH = 3;

  // Mode field encoding, 00 timer up to 11 measurement
  typedef enum logic [1:0] {MODE_TIMER, MODE_EVENT, MODE_ONESHOT, MODE_MEASURE} mode_e;

  // Control register layout, bit 15 first
  typedef struct packed {
    logic [2:0] reserved;
    logic clockRequestStatus;
    logic sleepStatus;
    logic outputPolarity;
    logic powerDown;
    logic filterBypass;
    logic reloadOnWrap;
    logic outputEnable;
    logic upDown;
    logic inputPolarity;
    mode_e mode;
    logic timerReset;
    logic timerEnable;
  } timer_control_s;

  // One register write as presented to the register file
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_write_s;
endpackage

// [hdl/input_noise_filter.sv]
// Majority-free noise filter: output follows only a stable input
module input_noise_filter #(
  parameter int unsigned DEPTH = timer_ctl_pkg::FILTER_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sampleEn,
  input wire logic rawIn,
  output logic filtered
);
  logic [DEPTH-1:0] samples_reg;
  logic filtered_reg;
  logic allHigh, allLow;

  // A level passes only after DEPTH equal samples
  assign allHigh = &samples_reg;
  assign allLow = ~|samples_reg;
  assign filtered = filtered_reg;

  // Shift in samples, change output on agreement
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      samples_reg <= '0;
      filtered_reg <= 1'b0;
    end else if (sampleEn) begin
      samples_reg <= {samples_reg[DEPTH-2:0], rawIn};
      if (allHigh) filtered_reg <= 1'b1;
      else if (allLow) filtered_reg <= 1'b0;
    end
  end
endmodule

// [hdl/axi_lite_regs_slave.sv]
// AXI4-Lite slave front end for the timer register window
module axi_lite_regs_slave (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output timer_ctl_pkg::reg_write_s writeReq,
  output logic writeFire,
  output logic [11:0] readAddr,
  input wire logic [31:0] readData
);
  logic awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
  logic [11:0] awAddr_reg;
  logic [31:0] wData_reg, rdata_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic awTake, wTake, arTake, wrMapped, rdMapped;

  // Write channels close while a write answer is pending
  assign awready = !awHeld_reg && !bvalid_reg;
  assign wready = !wHeld_reg && !bvalid_reg;
  assign awTake = awvalid && awready;
  assign wTake = wvalid && wready;
  assign writeFire = (awHeld_reg || awTake) && (wHeld_reg || wTake);
  assign writeReq.addr = awHeld_reg ? awAddr_reg : awaddr;
  assign writeReq.data = wHeld_reg ? wData_reg : wdata;
  assign writeReq.strb = wHeld_reg ? wStrb_reg : wstrb;
  assign arready = !rvalid_reg;
  assign arTake = arvalid && arready;
  assign readAddr = araddr;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // Unmapped words answer with a slave error
  assign wrMapped = writeReq.addr[11:2] inside {timer_ctl_pkg::OFF_CONTROL[11:2],
    timer_ctl_pkg::OFF_RELOAD[11:2], timer_ctl_pkg::OFF_COUNT[11:2]};
  assign rdMapped = araddr[11:2] inside {timer_ctl_pkg::OFF_CONTROL[11:2],
    timer_ctl_pkg::OFF_RELOAD[11:2], timer_ctl_pkg::OFF_COUNT[11:2]};

  // Write side: hold whichever half came first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      bresp_reg <= timer_ctl_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (writeFire) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wrMapped ? timer_ctl_pkg::RESP_OKAY : timer_ctl_pkg::RESP_SLVERR;
      end else begin
        if (awTake) awHeld_reg <= 1'b1;
        if (awTake) awAddr_reg <= awaddr;
        if (wTake) wHeld_reg <= 1'b1;
        if (wTake) wData_reg <= wdata;
        if (wTake) wStrb_reg <= wstrb;
        if (bvalid_reg && bready) bvalid_reg <= 1'b0;
      end
    end
  end

  // Read side: data captured at the address edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= timer_ctl_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (arTake) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= readData;
        rresp_reg <= rdMapped ? timer_ctl_pkg::RESP_OKAY : timer_ctl_pkg::RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
endmodule

// [hdl/timer_sleep_reload_control.sv]
// 16-bit timer with sleep, power-down, filter and reload control
//
// Our own choice: the AXI4-Lite register port.
module timer_sleep_reload_control (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sleepRequest,
  input wire logic timerInputPin,
  output logic timerOutputPin,
  output logic clockRequest
);
  timer_ctl_pkg::timer_control_s ctl_reg, ctlNext, ctlView;
  timer_ctl_pkg::reg_write_s writeReq;
  logic [15:0] ctlBits;
  logic [15:0] count_reg, countNext;
  logic [15:0] reload_reg, reloadNext, reloadMerged;
  logic oneShotRun_reg, runNext;
  logic measArmed_reg, armNext;
  logic outLevel_reg, outLevelNext;
  logic prevIn_reg;
  logic clockRequest_reg, clockRequestNext;
  logic timerOutputPin_reg, pinNext;
  logic writeFire;
  logic [11:0] readAddr;
  logic [31:0] readData;
  logic filtered, inSelected, inLevel, inEdge;
  logic timerGate, holdReset, enableClr, toggle, doStep, stepUp;
  logic writeCtl, writeReload, hitCtl, hitReload, hitCount;
  logic rawOut;

  axi_lite_regs_slave busSlave (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .writeReq(writeReq),
    .writeFire(writeFire),
    .readAddr(readAddr),
    .readData(readData)
  );

  assign timerGate = clkEn && !ctl_reg.powerDown;

  input_noise_filter #(
    .DEPTH(timer_ctl_pkg::FILTER_DEPTH)
  ) inFilter (
    .clk_sys(clk_sys),
    .rst(rst),
    .sampleEn(timerGate),
    .rawIn(timerInputPin),
    .filtered(filtered)
  );

  assign inSelected = ctl_reg.filterBypass ? timerInputPin : filtered;
  assign inLevel = ctl_reg.inputPolarity ? inSelected : !inSelected;
  assign inEdge = inLevel && !prevIn_reg;

  // Word decode of the register window
  assign writeCtl = writeFire && (writeReq.addr[11:2] == timer_ctl_pkg::OFF_CONTROL[11:2]);
  assign writeReload = writeFire && (writeReq.addr[11:2] == timer_ctl_pkg::OFF_RELOAD[11:2]);
  assign hitCtl = readAddr[11:2] == timer_ctl_pkg::OFF_CONTROL[11:2];
  assign hitReload = readAddr[11:2] == timer_ctl_pkg::OFF_RELOAD[11:2];
  assign hitCount = readAddr[11:2] == timer_ctl_pkg::OFF_COUNT[11:2];

  // sleep and the reset bit both hold the count
  assign holdReset = sleepRequest || ctl_reg.timerReset;

  // Reload lanes; measurement owns the register, so writes drop
  always_comb begin
    reloadMerged = reload_reg;
    if (writeReload && (ctl_reg.mode != timer_ctl_pkg::MODE_MEASURE)) begin
      if (writeReq.strb[0]) reloadMerged[7:0] = writeReq.data[7:0];
      if (writeReq.strb[1]) reloadMerged[15:8] = writeReq.data[15:8];
    end
  end

  // Counter next state per mode
  always_comb begin
    countNext = count_reg;
    reloadNext = reloadMerged;
    runNext = oneShotRun_reg;
    armNext = measArmed_reg;
    enableClr = 1'b0;
    toggle = 1'b0;
    doStep = 1'b0;
    stepUp = 1'b0;
    if (holdReset) begin
      countNext = reload_reg;
      runNext = 1'b0;
      armNext = 1'b0;
    end else if (ctl_reg.mode == timer_ctl_pkg::MODE_ONESHOT) begin
      if (oneShotRun_reg) begin
        // one-shot ends at zero, no reload
        if (count_reg == timer_ctl_pkg::WRAP_LOW) runNext = 1'b0;
        else countNext = count_reg - timer_ctl_pkg::STEP_ONE;
      end else if (ctl_reg.timerEnable) begin
        runNext = 1'b1;
        enableClr = 1'b1;
        countNext = reload_reg;
      end
    end else if (ctl_reg.timerEnable) begin
      // an enabled timer counts on from its current count, without a reload
      // mode field picks the count source
      unique case (ctl_reg.mode)
        timer_ctl_pkg::MODE_TIMER: doStep = !(ctl_reg.upDown && !inLevel);
        timer_ctl_pkg::MODE_EVENT: begin
          doStep = inEdge;
          stepUp = ctl_reg.upDown;
        end
        timer_ctl_pkg::MODE_ONESHOT: doStep = 1'b0;
        timer_ctl_pkg::MODE_MEASURE: begin
          if (inEdge) begin
            if (measArmed_reg) reloadNext = count_reg;
            countNext = timer_ctl_pkg::WRAP_LOW;
            armNext = 1'b1;
          end else if (count_reg == timer_ctl_pkg::WRAP_HIGH) begin
            reloadNext = timer_ctl_pkg::WRAP_LOW;
            enableClr = 1'b1;
          end else begin
            countNext = count_reg + timer_ctl_pkg::STEP_ONE;
          end
        end
      endcase
      if (doStep && stepUp) begin
        if (count_reg == timer_ctl_pkg::WRAP_HIGH) begin
          toggle = 1'b1;
          countNext = ctl_reg.reloadOnWrap ? reload_reg : timer_ctl_pkg::WRAP_LOW;
        end else begin
          countNext = count_reg + timer_ctl_pkg::STEP_ONE;
        end
      end else if (doStep) begin
        if (count_reg == timer_ctl_pkg::WRAP_LOW) begin
          toggle = 1'b1;
          // else roll under to all ones
          countNext = ctl_reg.reloadOnWrap ? reload_reg : timer_ctl_pkg::WRAP_HIGH;
        end else begin
          countNext = count_reg - timer_ctl_pkg::STEP_ONE;
        end
      end
    end
  end

  // Control next value: hardware clears first, then the software write
  always_comb begin
    ctlBits = ctl_reg;
    if (timerGate && (ctl_reg.timerReset || enableClr)) ctlBits[0] = 1'b0;
    if (timerGate && ctl_reg.timerReset) ctlBits[1] = 1'b0;
    // status and reserved bits are masked off
    if (writeCtl && writeReq.strb[0]) begin
      ctlBits[7:0] = writeReq.data[7:0] & timer_ctl_pkg::CONTROL_WRITABLE[7:0];
    end
    if (writeCtl && writeReq.strb[1]) begin
      ctlBits[15:8] = writeReq.data[15:8] & timer_ctl_pkg::CONTROL_WRITABLE[15:8];
    end
    ctlNext = timer_ctl_pkg::timer_control_s'(ctlBits);
  end

  // request the clock only while counting can happen
  assign clockRequestNext = !sleepRequest && !ctl_reg.powerDown
    && (ctl_reg.timerEnable || oneShotRun_reg || ctl_reg.timerReset);

  // Output level cleared while the timer is stopped
  assign outLevelNext = (!ctl_reg.timerEnable || holdReset) ? 1'b0 : (outLevel_reg ^ toggle);
  assign rawOut = (ctl_reg.mode == timer_ctl_pkg::MODE_ONESHOT) ? oneShotRun_reg : outLevel_reg;

  // polarity sets pulse or idle level; disabled pin drives low
  assign pinNext = ctl_reg.outputEnable ? (rawOut ^ ctl_reg.outputPolarity) : 1'b0;

  // Read view with live status bits
  always_comb begin
    ctlView = ctl_reg;
    ctlView.reserved = '0;
    ctlView.clockRequestStatus = clockRequest_reg;
    ctlView.sleepStatus = sleepRequest;
  end

  // control word at offset zero, upper half zero
  assign readData = hitCtl ? {16'h0000, ctlView}
    : hitReload ? {16'h0000, reload_reg}
    : hitCount ? {16'h0000, count_reg}
    : 32'h0000_0000;

  assign clockRequest = clockRequest_reg;
  assign timerOutputPin = timerOutputPin_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_reg <= timer_ctl_pkg::timer_control_s'(timer_ctl_pkg::CONTROL_RESET);
    end else if (clkEn) begin
      ctl_reg <= ctlNext;
    end
  end

  // Reload keeps accepting writes while powered down
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reload_reg <= timer_ctl_pkg::RELOAD_RESET;
    end else if (clkEn) begin
      reload_reg <= ctl_reg.powerDown ? reloadMerged : reloadNext;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= timer_ctl_pkg::RELOAD_RESET;
      oneShotRun_reg <= 1'b0;
      measArmed_reg <= 1'b0;
      outLevel_reg <= 1'b0;
      prevIn_reg <= 1'b0;
    end else if (timerGate) begin
      count_reg <= countNext;
      oneShotRun_reg <= runNext;
      measArmed_reg <= armNext;
      outLevel_reg <= outLevelNext;
      prevIn_reg <= inLevel;
    end
  end

  // Pin and clock request registered so the status bit matches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clockRequest_reg <= 1'b0;
      timerOutputPin_reg <= 1'b0;
    end else if (clkEn) begin
      clockRequest_reg <= clockRequestNext;
      timerOutputPin_reg <= pinNext;
    end
  end
endmodule

// [test/timer_sleep_reload_control_assertions.sv]
// Port-level checks of the timer control block
module timer_sleep_reload_control_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic sleepRequest,
  input wire logic clockRequest
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_write_answer;
    awvalid && awready && wvalid && wready && clkEn |=> bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("bvalid late");
  property p_read_answer;
    arvalid && arready && clkEn |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("rvalid late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_ar_refuse;
    rvalid |-> !arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("arready during rvalid");
  property p_aw_refuse;
    bvalid |-> !awready && !wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("awready during bvalid");
  property p_upper_zero;
    rvalid && rresp == timer_ctl_pkg::RESP_OKAY |-> rdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper rdata set");
  property p_sleep_clkreq;
    (clkEn && sleepRequest) [*2] |=> !clockRequest;
  endproperty
  a_sleep_clkreq: assert property (p_sleep_clkreq) else $error("clockRequest in sleep");
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_sleep: cover property ($fell(clockRequest) && sleepRequest);
endmodule

bind timer_sleep_reload_control timer_sleep_reload_control_assertions chk (
  .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp), .sleepRequest(sleepRequest), .clockRequest(clockRequest));

// [test/tb.sv]
// Register-level testbench of the timer control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, clkEn, awvalid, wvalid, bready, arvalid, rready;
  logic sleepRequest, timerInputPin, awready, wready, bvalid, arready, rvalid;
  logic timerOutputPin, clockRequest;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rd2;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, ws;
  int fail_count, checks_done;
  // Wrap cases: reload, control, count after two edges
  logic [15:0] tRel [4] = '{16'h0001, 16'h0001, 16'hfffe, 16'hfffe};
  logic [15:0] tCtl [4] = '{16'h0115, 16'h0195, 16'h0135, 16'h01b5};
  logic [15:0] tExp [4] = '{16'hffff, 16'h0001, 16'h0000, 16'hfffe};

  timer_sleep_reload_control uut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .sleepRequest(sleepRequest),
    .timerInputPin(timerInputPin), .timerOutputPin(timerOutputPin),
    .clockRequest(clockRequest));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic hang(input string name);
    fail_count++;
    $display("Error %s expected answer seen timeout", name);
    test_done();
  endtask

  // Ready is sampled at the falling edge, which equals its value at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    int n;
    logic ta, tw, tk;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid && bready;
      ws = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) begin
        bready <= 1'b0;
        break;
      end
      bready <= (n > 1); // Late ready exercises the held response
    end
    if (n == 50) hang("write");
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tk;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tk = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (tk) begin
        rready <= 1'b0;
        break;
      end
      rready <= (n > 1);
    end
    if (n == 50) hang("read");
  endtask

  task automatic rc(input string name, input logic [11:0] a, input logic [31:0] e);
    rdr(a, rd, rs);
    check(name, e, rd);
  endtask

  task automatic pulse(input int hi, input int lo);
    timerInputPin <= 1'b1;
    repeat (hi) @(posedge clk_sys);
    timerInputPin <= 1'b0;
    repeat (lo) @(posedge clk_sys);
  endtask

  initial begin
    {rst, clkEn, awvalid, wvalid, bready, arvalid, rready} = 7'h60;
    {sleepRequest, timerInputPin, awaddr, araddr, wdata, wstrb} = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rc("control_reset", timer_ctl_pkg::OFF_CONTROL, 32'h00000200);
    rc("reload_reset", timer_ctl_pkg::OFF_RELOAD, 32'h0000ffff);
    rdr(12'h010, rd, rs);
    check("unmapped_resp", {30'h0, timer_ctl_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(12'h010, 16'h1234);
    check("unmapped_wresp", {30'h0, timer_ctl_pkg::RESP_SLVERR}, {30'h0, ws});
    // Idle output level follows polarity
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h0040);
    check("control_wresp", {30'h0, timer_ctl_pkg::RESP_OKAY}, {30'h0, ws});
    repeat (3) @(posedge clk_sys);
    check("pin_active_high", 32'h0, {31'h0, timerOutputPin});
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h0440);
    repeat (3) @(posedge clk_sys);
    check("pin_active_low", 32'h1, {31'h0, timerOutputPin});
    // Every mode code reads back, request low while stopped
    for (int m = 0; m < 4; m++) begin
      wr(timer_ctl_pkg::OFF_CONTROL, 16'(m << 2));
      rc("mode_field", timer_ctl_pkg::OFF_CONTROL, 32'(m << 2));
      check("req_stopped", 32'h0, {31'h0, clockRequest});
    end
    // Measurement mode owns the reload register
    wr(timer_ctl_pkg::OFF_RELOAD, 16'h0100);
    rc("reload_locked", timer_ctl_pkg::OFF_RELOAD, 32'h0000ffff);
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h0000);
    wr(timer_ctl_pkg::OFF_RELOAD, 16'h0100);
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h1801);
    rc("status_ignored", timer_ctl_pkg::OFF_CONTROL, 32'h00001001);
    check("req_running", 32'h1, {31'h0, clockRequest});
    // Sleep holds count at reload and keeps enable
    sleepRequest <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rc("sleep_control", timer_ctl_pkg::OFF_CONTROL, 32'h00000801);
    rc("sleep_count", timer_ctl_pkg::OFF_COUNT, 32'h00000100);
    check("sleep_req", 32'h0, {31'h0, clockRequest});
    sleepRequest <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rdr(timer_ctl_pkg::OFF_COUNT, rd, rs);
    check("restart", 32'h1, {31'h0, rd[15:0] < 16'h0100 && rd[15:0] > 16'h00c0});
    // Power-down freezes the count
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h0201);
    rdr(timer_ctl_pkg::OFF_COUNT, rd2, rs);
    repeat (5) @(posedge clk_sys);
    rc("frozen_count", timer_ctl_pkg::OFF_COUNT, rd2);
    // Event counting across both wrap directions
    for (int i = 0; i < 4; i++) begin
      wr(timer_ctl_pkg::OFF_RELOAD, tRel[i]);
      wr(timer_ctl_pkg::OFF_CONTROL, 16'h0002);
      wr(timer_ctl_pkg::OFF_CONTROL, tCtl[i]);
      pulse(4, 4);
      pulse(4, 4);
      rc("wrap_count", timer_ctl_pkg::OFF_COUNT, {16'h0000, tExp[i]});
    end
    // Filter rejects a one-cycle glitch, passes a steady pulse
    wr(timer_ctl_pkg::OFF_RELOAD, 16'h0010);
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h0002);
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h0015);
    pulse(1, 6);
    rc("glitch_count", timer_ctl_pkg::OFF_COUNT, 32'h00000010);
    pulse(6, 6);
    rc("filtered_count", timer_ctl_pkg::OFF_COUNT, 32'h0000000f);
    // One-shot: active-low pulse, reload bit ignored at zero
    wr(timer_ctl_pkg::OFF_RELOAD, 16'h0004);
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h0002);
    wr(timer_ctl_pkg::OFF_CONTROL, 16'h04c9);
    @(negedge clk_sys);
    check("oneshot_pulse", 32'h0, {31'h0, timerOutputPin});
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("oneshot_idle", 32'h1, {31'h0, timerOutputPin});
    @(posedge clk_sys);
    rc("oneshot_count", timer_ctl_pkg::OFF_COUNT, 32'h00000000);
    rc("oneshot_ctl", timer_ctl_pkg::OFF_CONTROL, 32'h000004c8);
    test_done();
  end
endmodule
